// [design/system_clock_control.sv]
// Summary of operation
// - Oscillator source comes from start-up option bits.
// - Internal RC runs at 8, 4, 1 or 0.5 MHz.
// - Divider field divides clock by 1, 2, 8, 16.
// - Bit 7 enables external interrupt wake from Stop.
// - Reset enables wake-up and selects divide by 16.
// - Stop freezes main oscillator, CPU, peripheral clocks.
// - Only reset or filtered external interrupts end Stop.
// - Ring oscillator may keep running in Stop.
// - Idle gates only the CPU clock off.
// - Any interrupt or reset ends Idle.
// - Trim writes need the key value loaded first.
// - Trim loads factory value at reset.
// - Trim holds 0x00 to 0x7F; lower is faster.
// - Source bit 0 picks main or sub clock.
// - Source bit 3 stops or runs main oscillator.
// - Source bit 2 stops or runs sub oscillator.
// - One source write sets select, main stop and sub stop.
`include "system_clock_control_regs.svh"

module system_clock_control
	import system_clock_control_pkg::*;
(
	input  logic         clk,
	input  logic         rst,
	input  logic [11:0]  s_axi_awaddr,
	input  logic         s_axi_awvalid,
	output logic         s_axi_awready,
	input  logic [31:0]  s_axi_wdata,
	input  logic [3:0]   s_axi_wstrb,
	input  logic         s_axi_wvalid,
	output logic         s_axi_wready,
	output logic [1:0]   s_axi_bresp,
	output logic         s_axi_bvalid,
	input  logic         s_axi_bready,
	input  logic [11:0]  s_axi_araddr,
	input  logic         s_axi_arvalid,
	output logic         s_axi_arready,
	output logic [31:0]  s_axi_rdata,
	output logic [1:0]   s_axi_rresp,
	output logic         s_axi_rvalid,
	input  logic         s_axi_rready,
	input  logic [7:0]   option_bits,
	input  logic [6:0]   factory_trim,
	input  logic         main_osc_pin,
	input  logic         sub_osc_pin,
	input  logic [7:0]   external_irq_lines,
	input  logic         internal_irq,
	input  logic         stop_request,
	input  logic         idle_request,
	input  logic         ring_osc_request,
	output osc_source_e  osc_source,
	output logic [6:0]   osc_trim,
	output logic         main_osc_run,
	output logic         sub_osc_run,
	output logic         ring_osc_run,
	output logic         cpu_clk_en,
	output logic         periph_clk_en,
	output power_state_e power_state
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [7:0]   div_control;
	logic [7:0]   source_control;
	logic [7:0]   trim_key;
	logic         option_loaded;
	logic [9:0]   pin_meta;
	logic [9:0]   pin_sync;
	logic [9:0]   pin_prev;
	logic [7:0]   irq_filt;
	logic         aw_held;
	logic         w_held;
	logic [11:0]  aw_addr;
	logic [31:0]  w_data;
	logic [3:0]   w_strb;
	logic         do_write;
	logic         wr_mapped;
	logic [7:0]   wr_index;
	logic         wr_low;
	logic         wr_hit_trim;
	logic         wr_hit_key;
	logic         wr_hit_div;
	logic         wr_hit_source;
	logic [7:0]   rd_byte;
	logic         rd_mapped;
	logic         any_irq;
	logic         wake_allowed;
	logic         main_running;
	logic         main_edge;
	logic         sub_edge;
	logic         sel_tick;
	logic         div_tick;
	power_state_e next_state;

	// ****************************************************************
	// Start-up option capture
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			option_loaded <= 1'b0;
			osc_source    <= src_ext_crystal;
		end
		else if (!option_loaded)
		begin
			option_loaded <= 1'b1;
			osc_source    <= decode_source(option_bits[`OPTION_SOURCE_MSB:`OPTION_SOURCE_LSB]);
		end
	end

	// ****************************************************************
	// Pin synchronisers and interrupt filter
	// ****************************************************************
	genvar i;
	generate
		for (i = 0; i < 10; i++)
		begin : g_sync
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					pin_meta[i] <= 1'b0;
					pin_sync[i] <= 1'b0;
					pin_prev[i] <= 1'b0;
				end
				else
				begin
					pin_meta[i] <= (i < 8) ? external_irq_lines[i % 8]
						: ((i == 8) ? main_osc_pin : sub_osc_pin);
					pin_sync[i] <= pin_meta[i];
					pin_prev[i] <= pin_sync[i];
				end
			end
			if (i < 8)
			begin : g_filt
				// A line must stay high two samples to count, rejecting glitches.
				always_ff @(posedge clk)
				begin
					if (rst)
						irq_filt[i] <= 1'b0;
					else
						irq_filt[i] <= pin_sync[i] & pin_prev[i];
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Register bus write path
	// ****************************************************************
	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;
	assign do_write      = aw_held && w_held && !s_axi_bvalid;
	assign wr_index      = aw_addr[9:2];
	assign wr_mapped     = (aw_addr[11:10] == 2'h0) &&
		((wr_index == `TRIM_VALUE_INDEX) || (wr_index == `TRIM_KEY_INDEX) ||
		(wr_index == `DIV_CONTROL_INDEX) || (wr_index == `SOURCE_CONTROL_INDEX));
	assign wr_low        = do_write && wr_mapped && w_strb[0];
	assign wr_hit_trim   = wr_low && (wr_index == `TRIM_VALUE_INDEX);
	assign wr_hit_key    = wr_low && (wr_index == `TRIM_KEY_INDEX);
	assign wr_hit_div    = wr_low && (wr_index == `DIV_CONTROL_INDEX);
	assign wr_hit_source = wr_low && (wr_index == `SOURCE_CONTROL_INDEX);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			aw_held <= 1'b0;
			aw_addr <= 12'h000;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		else if (do_write)
			aw_held <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		else if (do_write)
			w_held <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_DECERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			div_control    <= `DIV_CONTROL_RESET;
			source_control <= `SOURCE_CONTROL_RESET;
		end
		else
		begin
			if (wr_hit_div)
				div_control <= w_data[7:0] & `DIV_CONTROL_MASK;
			if (wr_hit_source)
				source_control <= w_data[7:0] & `SOURCE_CONTROL_MASK;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			trim_key <= `TRIM_KEY_RESET;
			osc_trim <= factory_trim;
		end
		else
		begin
			if (wr_hit_key)
				trim_key <= w_data[7:0];
			if (wr_hit_trim && (trim_key == `TRIM_KEY_VALUE))
				osc_trim <= w_data[6:0];
		end
	end

	// ****************************************************************
	// Register bus read path
	// ****************************************************************
	always_comb
	begin
		rd_mapped = (s_axi_araddr[11:10] == 2'h0);
		case (s_axi_araddr[9:2])
			`TRIM_VALUE_INDEX:     rd_byte = {1'b0, osc_trim};
			`TRIM_KEY_INDEX:       rd_byte = trim_key;
			`DIV_CONTROL_INDEX:    rd_byte = div_control;
			`SOURCE_CONTROL_INDEX: rd_byte = source_control;
			default:
			begin
				rd_byte   = 8'h00;
				rd_mapped = 1'b0;
			end
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mapped ? {24'h000000, rd_byte} : 32'h00000000;
			s_axi_rresp  <= rd_mapped ? `RESP_OKAY : `RESP_DECERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ****************************************************************
	// Power-down modes
	// ****************************************************************
	assign any_irq      = (|irq_filt) || internal_irq;
	assign wake_allowed = div_control[`WAKE_ENABLE_BIT] && (|irq_filt);

	always_comb
	begin
		next_state = power_state;
		case (power_state)
			run_mode:
				if (stop_request)
					next_state = stop_mode;
				else if (idle_request)
					next_state = idle_mode;
			idle_mode:
				if (any_irq)
					next_state = run_mode;
			stop_mode:
				if (wake_allowed)
					next_state = run_mode;
			default:
				next_state = run_mode;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			power_state <= run_mode;
		else
			power_state <= next_state;
	end

	// ****************************************************************
	// Oscillator control and clock enables
	// ****************************************************************
	assign main_running = !source_control[`MAIN_STOP_BIT] && (power_state != stop_mode);
	assign main_edge    = pin_sync[8] && !pin_prev[8] && main_osc_run;
	assign sub_edge     = pin_sync[9] && !pin_prev[9] && sub_osc_run;
	assign sel_tick     = source_control[`CLOCK_SELECT_BIT] ? sub_edge : main_edge;

	clock_divider u_divider
	(
		.clk      (clk),
		.rst      (rst),
		.src_tick (sel_tick),
		.div_sel  (div_control[`DIV_SEL_MSB:`DIV_SEL_LSB]),
		.div_tick (div_tick)
	);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			main_osc_run  <= 1'b1;
			sub_osc_run   <= 1'b1;
			ring_osc_run  <= 1'b0;
			cpu_clk_en    <= 1'b0;
			periph_clk_en <= 1'b0;
		end
		else
		begin
			main_osc_run  <= main_running;
			sub_osc_run   <= !source_control[`SUB_STOP_BIT];
			ring_osc_run  <= ring_osc_request;
			cpu_clk_en    <= div_tick && (power_state == run_mode);
			periph_clk_en <= div_tick && (power_state != stop_mode);
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	option_capture_a: assert property (option_loaded && !$past(option_loaded) |->
		osc_source == decode_source($past(option_bits[2:0])))
		else $error("Source not taken from option bits.");
	option_stable_a: assert property (option_loaded |=> $stable(osc_source))
		else $error("Source changed after start-up.");
	divider_source_a: assert property (div_tick |-> $past(sel_tick))
		else $error("Divider ticked without a source edge.");
	wake_enable_a: assert property (power_state == stop_mode &&
		!div_control[7] |=> power_state == stop_mode)
		else $error("Stop ended with wake-up disabled.");
	reset_divider_a: assert property ($fell(rst) |-> div_control == 8'h98)
		else $error("Divider control reset value wrong.");
	stop_freeze_a: assert property (power_state == stop_mode |=>
		!main_osc_run && !cpu_clk_en && !periph_clk_en)
		else $error("Clock running in Stop.");
	stop_wake_a: assert property (power_state == stop_mode && div_control[7] &&
		(|irq_filt) |=> power_state == run_mode)
		else $error("Stop not released by interrupt.");
	stop_internal_a: assert property (power_state == stop_mode && !(|irq_filt)
		|=> power_state == stop_mode)
		else $error("Stop released without external interrupt.");
	ring_free_a: assert property (power_state == stop_mode |=>
		ring_osc_run == $past(ring_osc_request))
		else $error("Ring oscillator blocked in Stop.");
	idle_gate_a: assert property (power_state == idle_mode && div_tick |=>
		!cpu_clk_en && periph_clk_en)
		else $error("Idle gating wrong.");
	idle_exit_a: assert property (power_state == idle_mode && any_irq |=>
		power_state == run_mode)
		else $error("Idle not released by interrupt.");
	trim_locked_a: assert property (do_write && wr_index == 8'h17 &&
		trim_key != 8'hA5 |=> $stable(osc_trim))
		else $error("Trim written without key.");
	trim_reset_a: assert property ($fell(rst) |-> osc_trim == $past(factory_trim))
		else $error("Trim not loaded with factory value.");
	trim_write_a: assert property (wr_hit_trim && trim_key == 8'hA5 |=>
		osc_trim == $past(w_data[6:0]))
		else $error("Keyed trim write lost.");
	clock_select_a: assert property (source_control[0] && !sub_edge |=> !div_tick)
		else $error("Divider ticked without a sub clock edge.");
	main_stop_a: assert property (source_control[3] |=> !main_osc_run)
		else $error("Main oscillator not stopped.");
	sub_stop_a: assert property (source_control[2] ##1 source_control[2] |->
		!sub_osc_run)
		else $error("Sub oscillator not stopped.");
	source_write_a: assert property (wr_hit_source |=>
		source_control == ($past(w_data[7:0]) & 8'h0D))
		else $error("Source write not applied at once.");

	stop_wake_c: cover property (power_state == stop_mode ##1 power_state == run_mode);
	idle_exit_c: cover property (power_state == idle_mode ##1 power_state == run_mode);
	trim_write_c: cover property (wr_hit_trim && trim_key == 8'hA5);
	sub_clock_c: cover property (source_control[0] && cpu_clk_en);

endmodule : system_clock_control

// [design/system_clock_control_regs.svh]
`ifndef SYSTEM_CLOCK_CONTROL_REGS_SVH
`define SYSTEM_CLOCK_CONTROL_REGS_SVH

// ****************************************************************
// Register indices, byte address is four times the index
// ****************************************************************
`define TRIM_VALUE_INDEX      8'h17
`define TRIM_KEY_INDEX        8'h18
`define DIV_CONTROL_INDEX     8'hD4
`define SOURCE_CONTROL_INDEX  8'hFB

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define TRIM_KEY_RESET        8'h00
`define DIV_CONTROL_RESET     8'h98
`define SOURCE_CONTROL_RESET  8'h00
`define DIV_CONTROL_MASK      8'h98
`define SOURCE_CONTROL_MASK   8'h0D
`define TRIM_VALUE_MASK       8'h7F
`define TRIM_KEY_VALUE        8'hA5

// ****************************************************************
// Field positions
// ****************************************************************
`define WAKE_ENABLE_BIT       7
`define DIV_SEL_MSB           4
`define DIV_SEL_LSB           3
`define CLOCK_SELECT_BIT      0
`define SUB_STOP_BIT          2
`define MAIN_STOP_BIT         3
`define OPTION_SOURCE_MSB     2
`define OPTION_SOURCE_LSB     0

// ****************************************************************
// Divider terminal counts and bus answers
// ****************************************************************
`define DIV_TERM_1            4'h0
`define DIV_TERM_2            4'h1
`define DIV_TERM_8            4'h7
`define DIV_TERM_16           4'hF
`define RESP_OKAY             2'h0
`define RESP_DECERR           2'h3

`endif

// [design/system_clock_control_pkg.sv]
package system_clock_control_pkg;

	typedef enum logic [1:0] {run_mode, idle_mode, stop_mode} power_state_e;

	typedef enum logic [2:0]
	{
		src_ext_crystal,
		src_ext_rc,
		src_irc_8mhz,
		src_irc_4mhz,
		src_irc_1mhz,
		src_irc_500khz
	} osc_source_e;

	// Maps the option field to the oscillator source and RC frequency.
	function automatic osc_source_e decode_source(input logic [2:0] bits);
		case (bits)
			3'h1:    return src_ext_rc;
			3'h4:    return src_irc_8mhz;
			3'h5:    return src_irc_4mhz;
			3'h6:    return src_irc_1mhz;
			3'h7:    return src_irc_500khz;
			default: return src_ext_crystal;
		endcase
	endfunction : decode_source

endpackage : system_clock_control_pkg

// [design/clock_divider.sv]
`include "system_clock_control_regs.svh"

module clock_divider
	import system_clock_control_pkg::*;
(
	input  logic       clk,
	input  logic       rst,
	input  logic       src_tick,
	input  logic [1:0] div_sel,
	output logic       div_tick
);

	logic [3:0] count;
	logic [3:0] term;

	always_comb
	begin
		case (div_sel)
			2'h0:    term = `DIV_TERM_1;
			2'h1:    term = `DIV_TERM_2;
			2'h2:    term = `DIV_TERM_8;
			default: term = `DIV_TERM_16;
		endcase
	end

	// Comparing with >= lets a smaller setting take effect at once.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			count    <= 4'h0;
			div_tick <= 1'b0;
		end
		else
		begin
			div_tick <= 1'b0;
			if (src_tick)
			begin
				if (count >= term)
				begin
					count    <= 4'h0;
					div_tick <= 1'b1;
				end
				else
				begin
					count <= count + 4'h1;
				end
			end
		end
	end

endmodule : clock_divider

// [verification/osc_partner.sv]
module osc_partner
#(
	parameter int MAIN_HALF = 4,
	parameter int SUB_HALF  = 6
)
(
	input  wire logic clk,
	input  wire logic main_osc_run,
	input  wire logic sub_osc_run,
	output wire logic main_osc_pin,
	output wire logic sub_osc_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Oscillator sources
	// ****************************************************************
	// A stopped oscillator stands low instead of holding its last level.
	logic main_level = 1'b0;
	logic sub_level  = 1'b0;
	int   main_cnt   = 0;
	int   sub_cnt    = 0;

	assign main_osc_pin = main_level;
	assign sub_osc_pin  = sub_level;

	always @(posedge clk)
	begin
		if (!main_osc_run)
		begin
			main_cnt   <= 0;
			main_level <= 1'b0;
		end
		else if (main_cnt == MAIN_HALF - 1)
		begin
			main_cnt   <= 0;
			main_level <= !main_level;
		end
		else
			main_cnt <= main_cnt + 1;
	end

	always @(posedge clk)
	begin
		if (!sub_osc_run)
		begin
			sub_cnt   <= 0;
			sub_level <= 1'b0;
		end
		else if (sub_cnt == SUB_HALF - 1)
		begin
			sub_cnt   <= 0;
			sub_level <= !sub_level;
		end
		else
			sub_cnt <= sub_cnt + 1;
	end

endmodule : osc_partner

// [verification/system_clock_control_tb.sv]
`include "system_clock_control_regs.svh"

module system_clock_control_tb
	import system_clock_control_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Signals and model state
	// ****************************************************************
	localparam int DIVN [4] = '{1, 2, 8, 16};
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic [11:0]  s_axi_awaddr = 12'h000;
	logic         s_axi_awvalid = 1'b0;
	logic         s_axi_awready;
	logic [31:0]  s_axi_wdata = 32'h00000000;
	logic [3:0]   s_axi_wstrb = 4'hF;
	logic         s_axi_wvalid = 1'b0;
	logic         s_axi_wready;
	logic [1:0]   s_axi_bresp;
	logic         s_axi_bvalid;
	logic [11:0]  s_axi_araddr = 12'h000;
	logic         s_axi_arvalid = 1'b0;
	logic         s_axi_arready;
	logic [31:0]  s_axi_rdata;
	logic [1:0]   s_axi_rresp;
	logic         s_axi_rvalid;
	logic [7:0]   option_bits = 8'h04;
	logic [6:0]   factory_trim = 7'h40;
	logic         main_osc_pin;
	logic         sub_osc_pin;
	logic [7:0]   external_irq_lines = 8'h00;
	logic         internal_irq = 1'b0;
	logic         stop_request = 1'b0;
	logic         idle_request = 1'b0;
	logic         ring_osc_request = 1'b0;
	osc_source_e  osc_source;
	logic [6:0]   osc_trim;
	logic         main_osc_run;
	logic         sub_osc_run;
	logic         ring_osc_run;
	logic         cpu_clk_en;
	logic         periph_clk_en;
	power_state_e power_state;
	int           mismatches = 0;
	int           n_compared = 0;
	int           gap;
	int           nc;
	int           np;
	logic [31:0]  seed = 32'h00017F6C;
	logic [7:0]   m_trim;
	logic [7:0]   m_key;
	logic [7:0]   m_div;
	logic [7:0]   m_src;
	logic [1:0]   resp;
	logic [31:0]  rdat;

	always #2 clk = ~clk;

	system_clock_control dut_u (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .option_bits(option_bits),
		.factory_trim(factory_trim), .main_osc_pin(main_osc_pin), .sub_osc_pin(sub_osc_pin),
		.external_irq_lines(external_irq_lines), .internal_irq(internal_irq),
		.stop_request(stop_request), .idle_request(idle_request),
		.ring_osc_request(ring_osc_request), .osc_source(osc_source), .osc_trim(osc_trim),
		.main_osc_run(main_osc_run), .sub_osc_run(sub_osc_run), .ring_osc_run(ring_osc_run),
		.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .power_state(power_state));

	osc_partner partner_u (.clk(clk), .main_osc_run(main_osc_run), .sub_osc_run(sub_osc_run),
		.main_osc_pin(main_osc_pin), .sub_osc_pin(sub_osc_pin));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] lfsr_step(input logic [31:0] s);
		return {1'b0, s[31:1]} ^ (s[0] ? 32'hB4BCD35C : 32'h00000000);
	endfunction : lfsr_step

	function automatic logic [2:0] exp_src(input logic [2:0] b);
		case (b)
			3'h1:    return 3'h1;
			3'h4:    return 3'h2;
			3'h5:    return 3'h3;
			3'h6:    return 3'h4;
			3'h7:    return 3'h5;
			default: return 3'h0;
		endcase
	endfunction : exp_src

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic timeout();
		check("wait_limit", 32'h0, 32'h1);
		finish_test();
	endtask : timeout

	task automatic do_reset(input logic [7:0] opt);
		seed = lfsr_step(seed);
		option_bits  <= opt;
		factory_trim <= seed[6:0];
		rst          <= 1'b1;
		repeat (2) @(posedge clk);
		rst    <= 1'b0;
		m_trim = {1'b0, seed[6:0]};
		m_key  = `TRIM_KEY_RESET;
		m_div  = `DIV_CONTROL_RESET;
		m_src  = `SOURCE_CONTROL_RESET;
		repeat (2) @(posedge clk);
	endtask : do_reset

	task automatic axi_write(input logic [7:0] idx, input logic [31:0] d);
		int   n;
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done  = 1'b0;
		s_axi_awaddr  <= {2'h0, idx, 2'h0};
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_wvalid  <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge clk);
			if (aw_done && w_done && s_axi_bvalid === 1'b1)
				break;
			if (!aw_done && s_axi_awready === 1'b1)
			begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1)
			begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		if (n == 40)
			timeout();
		resp = s_axi_bresp;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] idx);
		int   n;
		logic ar_done;
		ar_done = 1'b0;
		s_axi_araddr  <= {2'h0, idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge clk);
			if (ar_done && s_axi_rvalid === 1'b1)
				break;
			if (!ar_done && s_axi_arready === 1'b1)
			begin
				ar_done = 1'b1;
				s_axi_arvalid <= 1'b0;
			end
		end
		if (n == 40)
			timeout();
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
	endtask : axi_read

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [1:0] er;
		er = `RESP_OKAY;
		case (idx)
			`TRIM_VALUE_INDEX:     if (m_key == `TRIM_KEY_VALUE) m_trim = d & `TRIM_VALUE_MASK;
			`TRIM_KEY_INDEX:       m_key = d;
			`DIV_CONTROL_INDEX:    m_div = d & `DIV_CONTROL_MASK;
			`SOURCE_CONTROL_INDEX: m_src = d & `SOURCE_CONTROL_MASK;
			default:               er = `RESP_DECERR;
		endcase
		axi_write(idx, {24'h0, d});
		check("bresp", resp, er);
	endtask : wr

	task automatic rd(input logic [7:0] idx);
		logic [7:0] ev;
		logic [1:0] er;
		er = `RESP_OKAY;
		case (idx)
			`TRIM_VALUE_INDEX:     ev = m_trim;
			`TRIM_KEY_INDEX:       ev = m_key;
			`DIV_CONTROL_INDEX:    ev = m_div;
			`SOURCE_CONTROL_INDEX: ev = m_src;
			default:
			begin
				ev = 8'h00;
				er = `RESP_DECERR;
			end
		endcase
		axi_read(idx);
		check("rdata", rdat, {24'h0, ev});
		check("rresp", resp, er);
	endtask : rd

	task automatic gap_of(output int g);
		int n;
		int c;
		g = 0;
		c = 0;
		for (n = 0; n < 1600 && c < 3; n++)
		begin
			@(posedge clk);
			if (cpu_clk_en === 1'b1)
			begin
				c++;
				if (c < 3)
					g = 1;
			end
			else
				g++;
		end
		if (c < 3)
			timeout();
	endtask : gap_of

	task automatic count_en(input int cyc, output int cn, output int pn);
		cn = 0;
		pn = 0;
		repeat (cyc)
		begin
			@(posedge clk);
			cn += (cpu_clk_en === 1'b1);
			pn += (periph_clk_en === 1'b1);
		end
	endtask : count_en

	task automatic pulse(input logic stop);
		if (stop)
			stop_request <= 1'b1;
		else
			idle_request <= 1'b1;
		@(posedge clk);
		stop_request <= 1'b0;
		idle_request <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : pulse

	task automatic wait_state(input power_state_e ps);
		for (int n = 0; n < 10 && power_state !== ps; n++)
			@(posedge clk);
		check("power_state", power_state, ps);
		if (power_state !== ps)
			finish_test();
	endtask : wait_state

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial
	begin
		for (int i = 0; i < 8; i++)
		begin
			do_reset({seed[15:11], 3'(i)});
			check("osc_source", osc_source, exp_src(3'(i)));
		end
		check("osc_trim", osc_trim, m_trim[6:0]);
		foreach (DIVN[i])
			rd(i == 0 ? `TRIM_VALUE_INDEX : i == 1 ? `TRIM_KEY_INDEX : i == 2 ?
				`DIV_CONTROL_INDEX : `SOURCE_CONTROL_INDEX);
		wr(`TRIM_VALUE_INDEX, seed[23:16]);
		wr(`TRIM_KEY_INDEX, 8'hA4);
		wr(`TRIM_VALUE_INDEX, 8'h11);
		rd(`TRIM_VALUE_INDEX);
		wr(`TRIM_KEY_INDEX, `TRIM_KEY_VALUE);
		foreach (DIVN[i])
		begin
			seed = lfsr_step(seed);
			wr(`TRIM_VALUE_INDEX, i == 0 ? 8'h00 : i == 1 ? 8'h7F : seed[7:0] | 8'h80);
			rd(`TRIM_VALUE_INDEX);
			check("osc_trim", osc_trim, m_trim[6:0]);
		end
		wr(8'h20, 8'h5A);
		rd(8'h20);
		for (int s = 0; s < 2; s++)
			for (int d = 0; d < 4; d++)
			begin
				wr(`SOURCE_CONTROL_INDEX, 8'(s));
				wr(`DIV_CONTROL_INDEX, 8'h80 | 8'(d << 3));
				gap_of(gap);
				check("cpu_gap", gap, DIVN[d] * (s ? 12 : 8));
			end
		wr(`SOURCE_CONTROL_INDEX, 8'h04);
		repeat (2) @(posedge clk);
		check("sub_osc_run", sub_osc_run, 1'b0);
		wr(`DIV_CONTROL_INDEX, 8'h98);
		wr(`SOURCE_CONTROL_INDEX, 8'h09);
		repeat (2) @(posedge clk);
		check("main_osc_run", main_osc_run, 1'b0);
		gap_of(gap);
		check("cpu_gap", gap, 16 * 12);
		wr(`SOURCE_CONTROL_INDEX, 8'h01);
		repeat (16) @(posedge clk);
		check("main_osc_run", main_osc_run, 1'b1);
		wr(`SOURCE_CONTROL_INDEX, 8'h00);
		gap_of(gap);
		check("cpu_gap", gap, 16 * 8);
		wr(`DIV_CONTROL_INDEX, 8'h80);
		pulse(1'b0);
		check("power_state", power_state, idle_mode);
		count_en(64, nc, np);
		check("idle_cpu", nc, 0);
		check("idle_periph", np != 0, 1'b1);
		internal_irq <= 1'b1;
		@(posedge clk);
		internal_irq <= 1'b0;
		wait_state(run_mode);
		pulse(1'b1);
		check("power_state", power_state, stop_mode);
		count_en(32, nc, np);
		check("stop_enables", nc + np, 0);
		check("main_osc_run", main_osc_run, 1'b0);
		internal_irq <= 1'b1;
		ring_osc_request <= 1'b1;
		repeat (3) @(posedge clk);
		internal_irq <= 1'b0;
		check("ring_osc_run", ring_osc_run, 1'b1);
		check("power_state", power_state, stop_mode);
		seed = lfsr_step(seed);
		external_irq_lines <= 8'h01 << seed[2:0];
		wait_state(run_mode);
		external_irq_lines <= 8'h00;
		ring_osc_request <= 1'b0;
		s_axi_wstrb <= 4'hE;
		axi_write(`DIV_CONTROL_INDEX, 32'h00000018);
		check("bresp", resp, `RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		check("ring_osc_run", ring_osc_run, 1'b0);
		rd(`DIV_CONTROL_INDEX);
		wr(`DIV_CONTROL_INDEX, 8'h18);
		pulse(1'b1);
		external_irq_lines <= 8'hFF;
		repeat (10) @(posedge clk);
		external_irq_lines <= 8'h00;
		check("power_state", power_state, stop_mode);
		do_reset(8'h00);
		check("power_state", power_state, run_mode);
		finish_test();
	end

endmodule : system_clock_control_tb
